// ===== src/lcd_core_pkg.sv
// Constants, register map and types shared by the LCD display core
package lcd_core_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_SEG = 40;
  localparam int NUM_BP = 4;
  localparam logic [5:0] RAM_LAST_ADDR = 6'h27;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_POINTER = 8'h04;
  localparam logic [7:0] ADDR_SUBADDR = 8'h08;
  localparam logic [7:0] ADDR_BANK = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PSAVE_BIT = 2;
  localparam int CTRL_BIAS_BIT = 3;
  localparam int BANK_IN_BIT = 0;
  localparam int BANK_OUT_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EXT_BIT = 1;
  localparam int STAT_MATCH_BIT = 2;
  localparam int STAT_PHASE_LSB = 4;

  // ==========================================================================
  // Drive modes, in field encoding order
  typedef enum logic [1:0] {
    MODE_STATIC,
    MODE_MUX2,
    MODE_MUX3,
    MODE_MUX4
  } drive_mode_t;

  typedef enum logic {
    ST_IDLE,
    ST_STORE
  } store_state_t;

  // ==========================================================================
  // Reset values
  localparam drive_mode_t MODE_RESET = MODE_MUX4;
  localparam logic BIAS_RESET = 1'b0;  // 0 selects one-third bias
  localparam logic PSAVE_RESET = 1'b0;
  localparam logic [5:0] POINTER_RESET = 6'h00;
  localparam logic [2:0] SUBADDR_RESET = 3'h0;
  localparam logic BANK_RESET = 1'b0;

  // ==========================================================================
  // Timing
  localparam int PCLK_HZ = 25_000_000;
  localparam int FRAME_HZ = 64;
  localparam int FRAME_DIV_NORMAL = 2880;
  localparam int FRAME_DIV_PSAVE = 480;
  // Internal oscillator: half-period counts giving a 64 Hz frame in each mode
  localparam int OSC_HALF_NORMAL = PCLK_HZ / (2 * FRAME_HZ * FRAME_DIV_NORMAL);
  localparam int OSC_HALF_PSAVE = PCLK_HZ / (2 * FRAME_HZ * FRAME_DIV_PSAVE);

endpackage : lcd_core_pkg

// ===== src/lcd_multiplex_display_core.sv
// LCD multiplex display core: display RAM, fill logic, scan and drive codes
`timescale 1ns/1ps
// Functional notes
// (RULE1) Frame is clock divided by 2880 or 480
// (RULE2) Select pin high: external clock on pin
// (RULE3) Select pin low: internal clock driven out
// (RULE4) Stretch bus while previous byte still storing
// (RULE5) Host supplies external clock above 125 kHz
// (RULE6) Shift next column while latch shows current
// (RULE7) Forty segment codes from phase and latch
// (RULE8) Three-plane mode: fourth backplane copies second
// (RULE9) Two-plane mode: backplanes pair zero/two, one/three
// (RULE10) Static mode: all backplanes identical
// (RULE11) Forty four-bit words, one means on
// (RULE12) Address maps segment, bit maps backplane
// (RULE13) Static: byte into bit zero, eight addresses
// (RULE14) Two-plane: byte into bits 0-1, four addresses
// (RULE15) Three-plane: three addresses, last bit two untouched
// (RULE16) Four-plane: byte into bits 0-3, two addresses
// (RULE17) Pointer loaded, advances 8, 4 or 2
// (RULE18) Store only when subaddress matches; pointer still advances
// (RULE19) Subaddress set by command, increments on overflow
// (RULE20) Planes scanned in order per mode
// (RULE21) Output bank shows bits two/three instead
// (RULE22) Input bank writes bits two/three independently
// (RULE23) Three-plane mode advances pointer by three
// (RULE24) Reset clears pointer, subaddress, banks; four-plane mode
module lcd_multiplex_display_core import lcd_core_pkg::*; (
  input wire logic pclk, // 25 MHz system clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic osc_select_pin, // High selects external clock
  input wire logic clk_pin_in, // Clock pin input level
  output logic clk_pin_out, // Clock pin output level
  output logic clk_pin_oe, // Clock pin output enable
  input wire logic [2:0] hw_subaddress_pins, // Strapped subaddress
  output logic scl_pin_out, // SCL output level (always low)
  output logic scl_pin_oe, // SCL pulled low while stretching
  output logic [2*NUM_SEG-1:0] segment_outputs, // Per segment {invert, on}
  output logic [2*NUM_BP-1:0] backplane_outputs // Per backplane {invert, active}
);

  // ==========================================================================
  // Pin synchronisers
  // Straps and pins are asynchronous to pclk, so each crosses two flops
  logic [1:0] sel_sync;
  logic [1:0] clk_sync;
  logic clk_last;
  logic [2:0] sub_meta;
  logic [2:0] hw_sub;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_sync <= 2'h0;
      clk_sync <= 2'h0;
      clk_last <= 1'b0;
      sub_meta <= 3'h0;
      hw_sub <= 3'h0;
    end else begin
      sel_sync <= {sel_sync[0], osc_select_pin};
      clk_sync <= {clk_sync[0], clk_pin_in};
      clk_last <= clk_sync[1];
      sub_meta <= hw_subaddress_pins;
      hw_sub <= sub_meta;
    end
  end

  // ==========================================================================
  // Control registers
  drive_mode_t mode;
  logic psave;
  logic bias;
  logic bank_in;
  logic bank_out;
  logic [5:0] pointer;
  logic [2:0] subaddr;
  store_state_t store_state;
  logic ext_clk;
  logic busy;
  logic acc;
  logic wr_ok;

  assign ext_clk = sel_sync[1];
  assign busy = (store_state == ST_STORE);
  assign acc = psel && penable;
  // Any write waits for the store in progress, so the pointer cannot move under it
  assign pready = !(busy && pwrite); // RULE4
  assign wr_ok = acc && pwrite && pready;
  assign scl_pin_out = 1'b0;
  assign scl_pin_oe = acc && pwrite && busy && (paddr == ADDR_DATA); // RULE4

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_RESET; // RULE24
      psave <= PSAVE_RESET;
      bias <= BIAS_RESET; // RULE24
      bank_in <= BANK_RESET; // RULE24
      bank_out <= BANK_RESET; // RULE24
    end else if (wr_ok && paddr == ADDR_CTRL) begin
      mode <= drive_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
      psave <= pwdata[CTRL_PSAVE_BIT];
      bias <= pwdata[CTRL_BIAS_BIT];
    end else if (wr_ok && paddr == ADDR_BANK) begin
      bank_in <= pwdata[BANK_IN_BIT]; // RULE22
      bank_out <= pwdata[BANK_OUT_BIT]; // RULE21
    end
  end

  // ==========================================================================
  // Display RAM fill
  logic [3:0] ram [NUM_SEG];
  logic [7:0] sh_byte;
  logic [3:0] bits_left;
  logic [2:0] bpa;
  logic [1:0] in_base;
  logic [3:0] take;
  logic match;

  always_comb begin
    unique case (mode)
      MODE_STATIC: bpa = 3'd1; // RULE13
      MODE_MUX2: bpa = 3'd2; // RULE14
      MODE_MUX3: bpa = 3'd3; // RULE15
      MODE_MUX4: bpa = 3'd4; // RULE16
    endcase
  end

  // Alternate bank only exists where the mode leaves bits two and three free
  assign in_base = (bank_in && (mode == MODE_STATIC || mode == MODE_MUX2)) ?
                   2'd2 : 2'd0; // RULE22
  assign take = (bits_left < {1'b0, bpa}) ? bits_left : {1'b0, bpa};
  assign match = (subaddr == hw_sub); // RULE18

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_state <= ST_IDLE;
      pointer <= POINTER_RESET; // RULE24
      subaddr <= SUBADDR_RESET; // RULE24
      sh_byte <= 8'h00;
      bits_left <= 4'h0;
      for (int a = 0; a < NUM_SEG; a++) begin
        ram[a] <= 4'h0;
      end
    end else begin
      unique case (store_state)
        ST_IDLE: begin
          if (wr_ok && paddr == ADDR_POINTER) begin
            pointer <= (pwdata[5:0] > RAM_LAST_ADDR) ? RAM_LAST_ADDR : pwdata[5:0]; // RULE17
          end
          if (wr_ok && paddr == ADDR_SUBADDR) begin
            subaddr <= pwdata[2:0]; // RULE19
          end
          if (wr_ok && paddr == ADDR_DATA) begin
            sh_byte <= pwdata[7:0];
            bits_left <= 4'd8;
            store_state <= ST_STORE;
          end
        end
        ST_STORE: begin
          // One address per cycle; most significant byte bit lands first
          // Writes stall while storing, so mode and bank cannot change mid-byte
          if (match) begin // RULE18
            for (int j = 0; j < 4; j++) begin
              if (j < int'(take)) begin // RULE15
                ram[pointer][2'(int'(in_base) + j)] <= sh_byte[7 - j]; // RULE13 RULE14 RULE16
              end
            end
          end
          sh_byte <= sh_byte << bpa;
          bits_left <= bits_left - take;
          // Per-address stepping gives 8, 4, 3 or 2 per byte
          // Wrapping past the last word hands the stream to the next cascaded driver
          if (pointer == RAM_LAST_ADDR) begin // RULE17 RULE23
            pointer <= 6'h00;
            subaddr <= subaddr + 3'd1; // RULE19
          end else begin
            pointer <= pointer + 6'd1; // RULE17 RULE23
          end
          if (bits_left <= {1'b0, bpa}) begin
            store_state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Clock source and pin
  logic [9:0] osc_cnt;
  logic [9:0] osc_half;
  logic int_clk;
  logic int_tick;
  logic tick;

  // Power-saving slows the internal oscillator sixfold to keep 64 Hz frames
  assign osc_half = psave ? 10'(OSC_HALF_PSAVE) : 10'(OSC_HALF_NORMAL);
  assign int_tick = (osc_cnt >= osc_half - 10'd1) && !int_clk;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt <= 10'h000;
      int_clk <= 1'b0;
    end else if (ext_clk) begin
      osc_cnt <= 10'h000; // RULE2
      int_clk <= 1'b0;
    end else if (osc_cnt >= osc_half - 10'd1) begin
      osc_cnt <= 10'h000;
      int_clk <= !int_clk; // RULE3
    end else begin
      osc_cnt <= osc_cnt + 10'd1;
    end
  end

  assign clk_pin_out = int_clk; // RULE3
  // The pin is an output only while the internal oscillator runs
  assign clk_pin_oe = !ext_clk; // RULE2 RULE3
  // Each pin level must last over one pclk period or an edge is missed
  assign tick = ext_clk ? (clk_sync[1] && !clk_last) : int_tick; // RULE2

  // ==========================================================================
  // Frame timing
  logic [11:0] phase_cnt;
  logic [11:0] phase_len;
  logic [1:0] phase;
  logic [1:0] last_phase;
  logic [1:0] next_phase;
  logic [1:0] load_phase;
  logic frame_inv;
  logic phase_end;

  always_comb begin
    unique case (mode)
      MODE_STATIC: last_phase = 2'd0; // RULE20
      MODE_MUX2: last_phase = 2'd1; // RULE20
      MODE_MUX3: last_phase = 2'd2; // RULE20
      MODE_MUX4: last_phase = 2'd3; // RULE20
    endcase
  end

  // Frame length split evenly over the active phases
  assign phase_len = 12'((psave ? FRAME_DIV_PSAVE : FRAME_DIV_NORMAL) /
                         (int'(last_phase) + 1)); // RULE1
  assign phase_end = tick && (phase_cnt >= phase_len - 12'd1);
  // After a mode change the phase may lie past the last active one; it
  // wraps to zero at the next phase end, so one odd phase can follow
  assign next_phase = (phase >= last_phase) ? 2'd0 : phase + 2'd1; // RULE20
  assign load_phase = (next_phase >= last_phase) ? 2'd0 : next_phase + 2'd1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_cnt <= 12'h000;
      phase <= 2'd0;
      frame_inv <= 1'b0;
    end else if (phase_end) begin
      phase_cnt <= 12'h000;
      phase <= next_phase;
      if (next_phase == 2'd0) begin
        frame_inv <= !frame_inv; // RULE1
      end
    end else if (tick) begin
      phase_cnt <= phase_cnt + 12'd1;
    end
  end

  // ==========================================================================
  // Shift register, latch and drive codes
  logic [1:0] rd_plane;
  logic [NUM_SEG-1:0] column;
  logic [NUM_SEG-1:0] shift_reg;
  logic [NUM_SEG-1:0] latch;

  assign rd_plane = (bank_out && (mode == MODE_STATIC || mode == MODE_MUX2)) ?
                    load_phase + 2'd2 : load_phase; // RULE21

  generate
    for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
      assign column[s] = ram[s][rd_plane]; // RULE11 RULE12
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          segment_outputs[2*s +: 2] <= 2'b00;
        end else begin
          segment_outputs[2*s +: 2] <= {frame_inv, latch[s]}; // RULE7
        end
      end
    end
  endgenerate

  // The column loaded here is shown one phase later, so the RAM stays
  // free for writes while the latch drives the current phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
      latch <= '0;
    end else if (phase_end) begin
      latch <= shift_reg; // RULE6
      shift_reg <= column; // RULE6
    end
  end

  generate
    for (genvar b = 0; b < NUM_BP; b++) begin : g_bp
      logic [1:0] own_phase;
      // Phases not owned by this backplane leave its active bit low
      always_comb begin
        unique case (mode)
          MODE_STATIC: own_phase = 2'd0; // RULE10
          MODE_MUX2: own_phase = 2'(b % 2); // RULE9
          MODE_MUX3: own_phase = (b == 3) ? 2'd1 : 2'(b); // RULE8
          MODE_MUX4: own_phase = 2'(b);
        endcase
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          backplane_outputs[2*b +: 2] <= 2'b00;
        end else begin
          backplane_outputs[2*b +: 2] <= {frame_inv, phase == own_phase}; // RULE12
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Register read path; data sampled in the setup cycle
  // Reads never stall: a pointer read during a store returns the
  // intermediate value, so software polls the busy bit first
  logic [31:0] next_rdata;
  logic mapped;

  always_comb begin
    next_rdata = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      ADDR_CTRL: begin
        next_rdata[CTRL_MODE_LSB +: 2] = mode;
        next_rdata[CTRL_PSAVE_BIT] = psave;
        next_rdata[CTRL_BIAS_BIT] = bias;
      end
      ADDR_POINTER: next_rdata[5:0] = pointer;
      ADDR_SUBADDR: next_rdata[2:0] = subaddr;
      ADDR_BANK: begin
        next_rdata[BANK_IN_BIT] = bank_in;
        next_rdata[BANK_OUT_BIT] = bank_out;
      end
      ADDR_DATA: next_rdata = 32'h0000_0000;
      ADDR_STATUS: begin
        next_rdata[STAT_BUSY_BIT] = busy;
        next_rdata[STAT_EXT_BIT] = ext_clk;
        next_rdata[STAT_MATCH_BIT] = match;
        next_rdata[STAT_PHASE_LSB +: 2] = phase;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Unmapped accesses complete like mapped ones (writes still stall while busy); only the error flag marks them
  assign pslverr = acc && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end

endmodule : lcd_multiplex_display_core

// ===== tb/ext_clock_source.sv
// External clock source that feeds the clock pin
`timescale 1ns/1ps
module ext_clock_source (
  input wire logic run, // Enables the clock
  output logic clk_out // Clock pin level
);
  // 6.25 MHz, far above the floor for full-rate bus traffic; still when off
  initial begin
    clk_out = 1'b0;
    #7;
    forever begin
      #80;
      clk_out = run ? !clk_out : 1'b0;
    end
  end
endmodule : ext_clock_source

// ===== tb/lcd_core_sva.sv
// Port checker for the LCD display core
`timescale 1ns/1ps
module lcd_core_sva import lcd_core_pkg::*; (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic osc_select_pin, // Clock select
  input wire logic clk_pin_oe, // Clock pin enable
  input wire logic scl_pin_out, // SCL level
  input wire logic scl_pin_oe, // SCL enable
  input wire logic [2*NUM_SEG-1:0] segment_outputs, // Segment codes
  input wire logic [2*NUM_BP-1:0] backplane_outputs // Backplane codes
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Mode tracking; the age counter skips the cycles where outputs still lag
  drive_mode_t mode;
  logic [1:0] age;
  logic [7:0] bp;
  assign bp = backplane_outputs;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_RESET;
      age <= 2'h0;
    end else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
      mode <= drive_mode_t'(pwdata[1:0]);
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  // ==========================================================================
  // Assertions
  scl_low_a: assert property (scl_pin_oe |-> !scl_pin_out)
    else $error("scl driven high");
  stretch_a: assert property (psel && penable && pwrite && paddr == ADDR_DATA
    && !pready |-> scl_pin_oe) else $error("no stretch while busy");
  stall_bound_a: assert property (!pready |-> ##[1:8] pready)
    else $error("stall too long");
  ext_clk_a: assert property (osc_select_pin [*5] |-> !clk_pin_oe)
    else $error("clock pin driven");
  int_clk_a: assert property (!osc_select_pin [*5] |-> clk_pin_oe)
    else $error("clock pin not driven");
  mux3_pair_a: assert property (age == 2'h3 && mode == MODE_MUX3
    |-> bp[7:6] == bp[3:2]) else $error("bp3 differs from bp1");
  mux2_pair_a: assert property (age == 2'h3 && mode == MODE_MUX2
    |-> bp[5:4] == bp[1:0] && bp[7:6] == bp[3:2]) else $error("bp pairs differ");
  static_same_a: assert property (age == 2'h3 && mode == MODE_STATIC
    |-> bp == {4{bp[1:0]}}) else $error("static bps differ");
  mux4_scan_a: assert property (age == 2'h3 && mode == MODE_MUX4
    |-> $onehot({bp[6], bp[4], bp[2], bp[0]})) else $error("not one bp active");
  seg_inv_a: assert property (segment_outputs[1] == bp[1]
    && segment_outputs[79] == bp[7]) else $error("segment inversion off");
  unmapped_a: assert property (psel && penable && (paddr > ADDR_STATUS || paddr[1:0] != 2'h0)
    |-> pslverr) else $error("unmapped without error");
endmodule : lcd_core_sva

bind lcd_multiplex_display_core lcd_core_sva chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .osc_select_pin, .clk_pin_oe, .scl_pin_out,
  .scl_pin_oe, .segment_outputs, .backplane_outputs);

// ===== tb/lcd_multiplex_display_core_tb.sv
// Self-checking testbench for the LCD display core
`timescale 1ns/1ps
module lcd_multiplex_display_core_tb import lcd_core_pkg::*;;
  localparam int TICK = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, scl_seen;
  logic osc_select_pin, clk_pin_in, clk_pin_out, clk_pin_oe, scl_pin_out, scl_pin_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] hw_subaddress_pins;
  logic [79:0] segment_outputs;
  logic [7:0] backplane_outputs;
  int err_total, num_checks, cycles, stalls, n;
  lcd_multiplex_display_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .osc_select_pin, .clk_pin_in, .clk_pin_out,
    .clk_pin_oe, .hw_subaddress_pins, .scl_pin_out, .scl_pin_oe, .segment_outputs,
    .backplane_outputs);
  ext_clock_source ext (.run(osc_select_pin), .clk_out(clk_pin_in));
  always #20 pclk = !pclk;
  // ==========================================================================
  // Tasks
  task automatic end_of_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    stalls = 0;
    // Request stands until pready is seen high at a rising edge
    do begin
      @(posedge pclk);
      stalls++;
      if (scl_pin_oe === 1'b1) scl_seen = 1'b1;
    end while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    // Reads never stall, so let any byte store finish first
    do apb(1'b0, ADDR_STATUS, 32'h0);
    while (q[STAT_BUSY_BIT] !== 1'b0);
    apb(1'b0, a, 32'h0);
    check(q, e, "read data");
  endtask : rd
  task automatic wait_frame();
    logic v;
    n = 0;
    v = backplane_outputs[1];
    while (backplane_outputs[1] === v && n < 20000) begin
      @(negedge pclk);
      n++;
    end
  endtask : wait_frame
  task automatic show(input int b, input logic [2:0] exp);
    while (backplane_outputs[2*b] !== 1'b1) @(negedge pclk);
    check({segment_outputs[4], segment_outputs[2], segment_outputs[0]}, exp, "segments");
  endtask : show
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 95000) begin
      err_total++;
      end_of_test();
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, osc_select_pin} = '0;
    {hw_subaddress_pins, scl_seen, err_total, num_checks, cycles} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, {30'h0, MODE_MUX4});
    rd(ADDR_POINTER, 32'h0);
    rd(ADDR_SUBADDR, 32'h0);
    rd(ADDR_BANK, 32'h0);
    rd(8'h18, 32'h0);
    check(serr, 1'b1, "slave error");
    check(clk_pin_oe, 1'b1, "clock enable");
    n = 0;
    while (clk_pin_out !== 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    check(clk_pin_out, 1'b1, "clock pin high");
    n = 0;
    while (clk_pin_out !== 1'b0 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    check(clk_pin_out, 1'b0, "clock pin low");
    osc_select_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    check(clk_pin_oe, 1'b0, "clock enable");
    wr(ADDR_CTRL, {29'h0, 1'b1, MODE_MUX4});
    wait_frame();
    wait_frame();
    check(n, FRAME_DIV_PSAVE * TICK, "frame length");
    wr(ADDR_POINTER, 32'h0);
    wr(ADDR_DATA, 32'hA5);
    rd(ADDR_POINTER, 32'h2);
    wr(ADDR_POINTER, 32'h2);
    wr(ADDR_DATA, 32'hF0);
    repeat (2) wait_frame();
    for (int b = 0; b < 4; b++) show(b, b[0] ? 3'b110 : 3'b101);
    wr(ADDR_CTRL, {29'h0, 1'b1, MODE_MUX3});
    wr(ADDR_POINTER, 32'h0);
    wr(ADDR_DATA, 32'h0);
    rd(ADDR_POINTER, 32'h3);
    wr(ADDR_SUBADDR, 32'h1);
    wr(ADDR_POINTER, 32'h0);
    wr(ADDR_DATA, 32'hFF);
    rd(ADDR_POINTER, 32'h3);
    repeat (2) wait_frame();
    show(0, 3'b000);
    show(2, 3'b100);
    wr(ADDR_POINTER, 32'd39);
    wr(ADDR_DATA, 32'h0);
    rd(ADDR_POINTER, 32'h2);
    rd(ADDR_SUBADDR, 32'h2);
    wr(ADDR_SUBADDR, 32'h0);
    wr(ADDR_CTRL, {29'h0, 1'b1, MODE_STATIC});
    wr(ADDR_POINTER, 32'h0);
    wr(ADDR_DATA, 32'h80);
    wr(ADDR_DATA, 32'h0);
    check(stalls > 1, 1'b1, "stall");
    check(scl_seen, 1'b1, "scl stretch");
    rd(ADDR_POINTER, 32'h10);
    wr(ADDR_BANK, 32'h1);
    wr(ADDR_POINTER, 32'h0);
    wr(ADDR_DATA, 32'h40);
    repeat (2) wait_frame();
    show(0, 3'b001);
    wr(ADDR_BANK, 32'h3);
    repeat (2) wait_frame();
    show(0, 3'b010);
    wr(ADDR_CTRL, {29'h0, 1'b1, MODE_MUX2});
    wr(ADDR_BANK, 32'h0);
    wr(ADDR_POINTER, 32'h0);
    wr(ADDR_DATA, 32'h90);
    rd(ADDR_POINTER, 32'h4);
    repeat (2) wait_frame();
    show(0, 3'b001);
    show(1, 3'b010);
    wr(ADDR_CTRL, {29'h0, 1'b0, MODE_MUX4});
    wait_frame();
    wait_frame();
    check(n, FRAME_DIV_NORMAL * TICK, "frame length");
    end_of_test();
  end
endmodule : lcd_multiplex_display_core_tb
